// >>> src/cfos_chan_timer.sv
// Per-channel on/off sequencing timer in millisecond ticks
`timescale 1ns/1ns
module cfos_chan_timer
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic on_ev_i,
    input wire logic off_ev_i,
    input wire logic [15:0] offset_i,
    input wire logic [15:0] don_i,
    input wire logic [15:0] doff_i,
    output logic out_o,
    output logic busy_o
);
    cfos_pkg::cfos_phase_t phase;
    logic target;
    logic [15:0] cnt;

    assign busy_o = phase != cfos_pkg::CFOS_IDLE;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase <= cfos_pkg::CFOS_IDLE;
            target <= 1'b0;
            cnt <= 16'h0000;
            out_o <= 1'b0;
        end
        else if (on_ev_i)
        begin
            phase <= cfos_pkg::CFOS_OFFSET; // R14
            target <= 1'b1;
            cnt <= offset_i;
        end
        else if (off_ev_i)
        begin
            phase <= cfos_pkg::CFOS_DELAY; // R15
            target <= 1'b0;
            cnt <= doff_i;
        end
        else
        begin
            unique case (phase)
                cfos_pkg::CFOS_IDLE:
                    cnt <= cnt;
                cfos_pkg::CFOS_OFFSET:
                    if (cnt == 16'h0000)
                    begin
                        phase <= cfos_pkg::CFOS_DELAY; // R14
                        cnt <= don_i;
                    end
                    else if (tick_i)
                        cnt <= cnt - 16'h0001;
                cfos_pkg::CFOS_DELAY:
                    if (cnt == 16'h0000)
                    begin
                        phase <= cfos_pkg::CFOS_IDLE;
                        out_o <= target;
                    end
                    else if (tick_i)
                        cnt <= cnt - 16'h0001;
                default:
                    phase <= cfos_pkg::CFOS_IDLE;
            endcase
        end
    end

    property p_off_no_offset;
        @(posedge clk_i) disable iff (rst_i)
        off_ev_i && !on_ev_i |=> phase == cfos_pkg::CFOS_DELAY && !target;
    endproperty
    a_off_no_offset: assert property (p_off_no_offset) else $error("off used offset"); // R15

    property p_on_offset_first;
        @(posedge clk_i) disable iff (rst_i)
        on_ev_i |=> phase == cfos_pkg::CFOS_OFFSET && cnt == $past(offset_i);
    endproperty
    a_on_offset_first: assert property (p_on_offset_first) else $error("on skipped offset"); // R14
endmodule : cfos_chan_timer

// >>> src/cfos_pkg.sv
// Constants and types for the cross-frame output synchronizer
// Operation
// R1: Each taking-part chassis has at least one output channel in the coupled set.
// R2: Cross-frame sync must be enabled on every chassis holding a synchronized channel.
// R3: With mixed minimum offsets, software programs one common offset before use.
// R4: That common offset equals the largest minimum offset over all chassis.
// R5: The same common offset value is written into every taking-part chassis.
// R6: Sync functions are accepted only on connector lines 4 to 7; others are rejected.
// R7: At most one line holds the on-sync function and one the off-sync function.
// R8: Sync line polarity is fixed; no setting inverts it.
// R9: Each assigned sync line both signals local events and receives peer events.
// R10: A falling edge on a sync line is the event every connected chassis acts on.
// R11: An on/off request to any coupled channel switches all coupled channels.
// R12: Front panel key, web server and remote command requests act identically.
// R13: With key coupling on, an event also switches local non-coupled channels.
// R14: On an on event each channel waits the common offset, then its own delay.
// R15: On an off event no offset applies; each turn-off delay starts at once.
// R16: Sync lines are open-drain with pull-up, pulled low briefly then released.
package cfos_pkg;
    localparam int NCH = 4;
    localparam int NPIN = 8;
    localparam int DW = 16;
    localparam logic [2:0] SYNC_PIN_LO = 3'h4;
    localparam logic [2:0] SYNC_PIN_HI = 3'h7;
    localparam int CLK_HZ = 25000000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
    localparam int PULSE_US = 10;
    localparam int PULSE_CYC = CLK_HZ / 1000000 * PULSE_US;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_PINFN = 8'h04;
    localparam logic [7:0] ADR_OFFSET = 8'h08;
    localparam logic [7:0] ADR_STATUS = 8'h0c;
    localparam logic [7:0] ADR_CMD = 8'h10;
    localparam logic [7:0] ADR_DON_BASE = 8'h20;
    localparam logic [7:0] ADR_DOFF_BASE = 8'h30;
    localparam int CTRL_EN = 0;
    localparam int CTRL_KEYC = 1;
    localparam int CTRL_COUP_LSB = 4;
    localparam int PIN_ON_LSB = 0;
    localparam int PIN_ON_VLD = 3;
    localparam int PIN_OFF_LSB = 4;
    localparam int PIN_OFF_VLD = 7;
    localparam int PIN_ERR = 8;
    localparam int CMD_ON = 0;
    localparam int CMD_OFF = 1;
    localparam logic [31:0] ERR_DATA = 32'h0000_0000;
    typedef enum logic [1:0]
    {
        CFOS_IDLE = 2'b00,
        CFOS_OFFSET = 2'b01,
        CFOS_DELAY = 2'b10
    } cfos_phase_t;
endpackage : cfos_pkg

// >>> src/cfos_sync_line.sv
// One open-drain sync line: drive a low pulse, detect falling edges
`timescale 1ns/1ns
module cfos_sync_line
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic fire_i,
    output logic pin_oe_o,
    output logic fall_o
);
    logic s1;
    logic s2;
    logic s3;
    logic [15:0] cnt;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end
        else
        begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Falling edge from any chassis, including this one
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            fall_o <= 1'b0;
        else
            fall_o <= s3 & ~s2; // R10
    end

    // Pull low for a fixed time, then release to the pull-up
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= 16'h0000;
            pin_oe_o <= 1'b0;
        end
        else if (fire_i && !pin_oe_o)
        begin
            cnt <= 16'(cfos_pkg::PULSE_CYC - 1);
            pin_oe_o <= 1'b1; // R16
        end
        else if (pin_oe_o)
        begin
            if (cnt == 16'h0000)
                pin_oe_o <= 1'b0; // R16
            else
                cnt <= cnt - 16'h0001;
        end
    end

    property p_release;
        @(posedge clk_i) disable iff (rst_i)
        $rose(pin_oe_o) |-> pin_oe_o [*8] ##[1:300] !pin_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("sync line not released"); // R16
endmodule : cfos_sync_line

// >>> src/cfos_top.sv
// Cross-frame output synchronizer with classic Wishbone registers
`timescale 1ns/1ns
module cfos_top
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic key_on_i,
    input wire logic key_off_i,
    input wire logic web_on_i,
    input wire logic web_off_i,
    input wire logic [7:0] dig_pin_i,
    output logic [7:0] dig_pin_o,
    output logic [7:0] dig_pin_oe_o,
    output logic [3:0] chan_out_o
);
    logic en;
    logic keyc;
    logic [3:0] coup;
    logic [2:0] on_pin;
    logic on_vld;
    logic [2:0] off_pin;
    logic off_vld;
    logic pin_err;
    logic [15:0] offset;
    logic [15:0] don [cfos_pkg::NCH];
    logic [15:0] doff [cfos_pkg::NCH];
    logic req_on;
    logic req_off;
    logic [15:0] tick_cnt;
    logic tick;
    logic [7:0] fire;
    logic [7:0] fall;
    logic [7:0] oe;
    logic on_ev;
    logic off_ev;
    logic [3:0] tout;
    logic [3:0] busy;
    logic wb_hit;
    logic wr;
    logic [1:0] ksync_on;
    logic [1:0] ksync_off;
    logic [1:0] wsync_on;
    logic [1:0] wsync_off;
    logic [2:0] wr_on_pin;
    logic [2:0] wr_off_pin;
    logic wr_on_ok;
    logic wr_off_ok;

    assign wb_hit = cyc_i && stb_i && !ack_o;
    assign wr = wb_hit && we_i && sel_i[0];
    assign wr_on_pin = dat_i[cfos_pkg::PIN_ON_LSB +: 3];
    assign wr_off_pin = dat_i[cfos_pkg::PIN_OFF_LSB +: 3];
    assign wr_on_ok = !dat_i[cfos_pkg::PIN_ON_VLD] || wr_on_pin >= cfos_pkg::SYNC_PIN_LO;
    assign wr_off_ok = !dat_i[cfos_pkg::PIN_OFF_VLD] || wr_off_pin >= cfos_pkg::SYNC_PIN_LO;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= wb_hit;
    end

    // Control, offset and delay registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            en <= 1'b0;
            keyc <= 1'b0;
            coup <= 4'h0;
            offset <= 16'h0000;
            for (int i = 0; i < cfos_pkg::NCH; i++)
            begin
                don[i] <= 16'h0000;
                doff[i] <= 16'h0000;
            end
        end
        else if (wr)
        begin
            if (adr_i == cfos_pkg::ADR_CTRL)
            begin
                en <= dat_i[cfos_pkg::CTRL_EN];
                keyc <= dat_i[cfos_pkg::CTRL_KEYC];
                coup <= dat_i[cfos_pkg::CTRL_COUP_LSB +: 4];
            end
            if (adr_i == cfos_pkg::ADR_OFFSET && sel_i[1])
                offset <= dat_i[15:0];
            for (int i = 0; i < cfos_pkg::NCH; i++)
            begin
                if (adr_i == cfos_pkg::ADR_DON_BASE + 8'(4 * i) && sel_i[1])
                    don[i] <= dat_i[15:0];
                if (adr_i == cfos_pkg::ADR_DOFF_BASE + 8'(4 * i) && sel_i[1])
                    doff[i] <= dat_i[15:0];
            end
        end
    end

    // Pin function assignment: lines 4..7 only, one on and one off line
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            on_pin <= 3'h0;
            on_vld <= 1'b0;
            off_pin <= 3'h0;
            off_vld <= 1'b0;
            pin_err <= 1'b0;
        end
        else if (wr && adr_i == cfos_pkg::ADR_PINFN)
        begin
            if (wr_on_ok && wr_off_ok && !(dat_i[cfos_pkg::PIN_ON_VLD]
                && dat_i[cfos_pkg::PIN_OFF_VLD] && wr_on_pin == wr_off_pin))
            begin
                on_pin <= wr_on_pin; // R7
                on_vld <= dat_i[cfos_pkg::PIN_ON_VLD];
                off_pin <= wr_off_pin; // R7
                off_vld <= dat_i[cfos_pkg::PIN_OFF_VLD];
                pin_err <= 1'b0;
            end
            else
                pin_err <= 1'b1; // R6
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= cfos_pkg::ERR_DATA;
        else if (wb_hit && !we_i)
            unique case (adr_i)
                cfos_pkg::ADR_CTRL:
                    dat_o <= {24'h00_0000, coup, 2'b00, keyc, en};
                cfos_pkg::ADR_PINFN:
                    dat_o <= {23'h00_0000, pin_err, off_vld, off_pin, on_vld, on_pin};
                cfos_pkg::ADR_OFFSET:
                    dat_o <= {16'h0000, offset};
                cfos_pkg::ADR_STATUS:
                    dat_o <= {24'h00_0000, busy, tout};
                default:
                    dat_o <= cfos_pkg::ERR_DATA;
            endcase
        else
            dat_o <= cfos_pkg::ERR_DATA;
    end

    // Key and web strobes come from outside: two flops each
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ksync_on <= 2'b00;
            ksync_off <= 2'b00;
            wsync_on <= 2'b00;
            wsync_off <= 2'b00;
        end
        else
        begin
            ksync_on <= {ksync_on[0], key_on_i};
            ksync_off <= {ksync_off[0], key_off_i};
            wsync_on <= {wsync_on[0], web_on_i};
            wsync_off <= {wsync_off[0], web_off_i};
        end
    end

    // All request sources merge into one on and one off request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            req_on <= 1'b0;
            req_off <= 1'b0;
        end
        else
        begin
            req_on <= ksync_on[1] || wsync_on[1]
                || (wr && adr_i == cfos_pkg::ADR_CMD && dat_i[cfos_pkg::CMD_ON]); // R12
            req_off <= ksync_off[1] || wsync_off[1]
                || (wr && adr_i == cfos_pkg::ADR_CMD && dat_i[cfos_pkg::CMD_OFF]); // R12
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || tick_cnt == 16'(cfos_pkg::TICK_CYC - 1))
            tick_cnt <= 16'h0000;
        else
            tick_cnt <= tick_cnt + 16'h0001;
    end
    assign tick = tick_cnt == 16'h0000;

    // Local request drives the sync line; the line's edge starts everyone
    always_comb
    begin
        fire = 8'h00;
        if (en && on_vld)
            fire[on_pin] = req_on; // R9
        if (en && off_vld)
            fire[off_pin] = req_off; // R9
    end

    // Polarity fixed: falling edge when sync enabled and line assigned, else the local request
    assign on_ev = en && on_vld ? fall[on_pin] : req_on; // R8
    assign off_ev = en && off_vld ? fall[off_pin] : req_off; // R8

    genvar g;
    generate
        for (g = 0; g < cfos_pkg::NPIN; g++)
        begin : g_line
            cfos_sync_line u_line
            (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pin_i(dig_pin_i[g]),
                .fire_i(fire[g]),
                .pin_oe_o(oe[g]),
                .fall_o(fall[g])
            );
        end
        for (g = 0; g < cfos_pkg::NCH; g++)
        begin : g_chan
            logic sel_ch;
            assign sel_ch = coup[g] || keyc; // R11 R13
            cfos_chan_timer u_timer
            (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .tick_i(tick),
                .on_ev_i(on_ev && sel_ch),
                .off_ev_i(off_ev && sel_ch),
                .offset_i(offset),
                .don_i(don[g]),
                .doff_i(doff[g]),
                .out_o(tout[g]),
                .busy_o(busy[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dig_pin_o <= 8'h00;
            dig_pin_oe_o <= 8'h00;
            chan_out_o <= 4'h0;
        end
        else
        begin
            dig_pin_o <= 8'h00; // R16
            dig_pin_oe_o <= oe;
            chan_out_o <= tout;
        end
    end

    property p_pin_range;
        @(posedge clk_i) disable iff (rst_i)
        (on_vld |-> on_pin >= cfos_pkg::SYNC_PIN_LO)
            and (off_vld |-> off_pin >= cfos_pkg::SYNC_PIN_LO);
    endproperty
    a_pin_range: assert property (p_pin_range) else $error("sync on bad line"); // R6

    property p_one_each;
        @(posedge clk_i) disable iff (rst_i)
        on_vld && off_vld |-> on_pin != off_pin;
    endproperty
    a_one_each: assert property (p_one_each) else $error("line has two functions"); // R7

    property p_fire_drive;
        @(posedge clk_i) disable iff (rst_i)
        en && on_vld && req_on && !oe[on_pin] |=> ##1 dig_pin_oe_o[on_pin];
    endproperty
    a_fire_drive: assert property (p_fire_drive) else $error("on line not driven"); // R9

    logic u_chan_busy0;
    assign u_chan_busy0 = busy[0];

    property p_fall_event;
        @(posedge clk_i) disable iff (rst_i)
        en && on_vld && fall[on_pin] && coup[0] |=> u_chan_busy0;
    endproperty
    a_fall_event: assert property (p_fall_event) else $error("edge missed"); // R10 R11

    property p_ack_one;
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held");

    property p_cmd_req;
        @(posedge clk_i) disable iff (rst_i)
        wr && adr_i == cfos_pkg::ADR_CMD && dat_i[cfos_pkg::CMD_ON] |=> req_on;
    endproperty
    a_cmd_req: assert property (p_cmd_req) else $error("command lost"); // R12
endmodule : cfos_top

// >>> verif/cfos_peer.sv
// Peer chassis model sharing the on and off sync lines
`timescale 1ns/1ns
module cfos_peer
#(
    parameter int ON_LINE = 6,
    parameter int OFF_LINE = 7,
    parameter bit SYNC_EN = 1'b1,
    parameter int PULSE = 250
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fire_on_i,
    input wire logic fire_off_i,
    input wire logic [7:0] wire_i,
    output logic [7:0] oe_o,
    output logic [7:0] on_falls_o,
    output logic [7:0] off_falls_o
);
    int on_left;
    int off_left;
    logic [7:0] last;
    // Pull a line low for one pulse, then hand it back to the pull-up
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            on_left <= 0;
            off_left <= 0;
        end
        else
        begin
            on_left <= (fire_on_i && SYNC_EN) ? PULSE : ((on_left > 0) ? on_left - 1 : 0);
            off_left <= (fire_off_i && SYNC_EN) ? PULSE : ((off_left > 0) ? off_left - 1 : 0);
        end
    end
    always_comb
    begin
        oe_o = 8'h00;
        oe_o[ON_LINE] = (on_left > 0);
        oe_o[OFF_LINE] = (off_left > 0);
    end
    // Count falling edges seen on the on and off sync lines
    always_ff @(posedge clk_i)
    begin
        last <= wire_i;
        if (rst_i)
        begin
            on_falls_o <= 8'h00;
            off_falls_o <= 8'h00;
        end
        else
        begin
            if (last[ON_LINE] && !wire_i[ON_LINE])
                on_falls_o <= on_falls_o + 8'h01;
            if (last[OFF_LINE] && !wire_i[OFF_LINE])
                off_falls_o <= off_falls_o + 8'h01;
        end
    end
endmodule : cfos_peer

// >>> verif/cfos_top_tb.sv
// Self-checking bench for the cross-frame output synchronizer
`timescale 1ns/1ns
module cfos_top_tb;
    localparam int OFS = 2;
    localparam int TICK = cfos_pkg::TICK_CYC;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic [3:0] req = 4'h0;
    logic [7:0] pin_oe;
    logic [7:0] pin_o;
    logic [7:0] peer_oe;
    logic [7:0] pin_lvl;
    logic [3:0] chan;
    logic fire_on = 1'b0;
    logic fire_off = 1'b0;
    logic [7:0] on_falls;
    logic [7:0] off_falls;
    int err_total = 0;
    int check_count = 0;
    assign pin_lvl = ~(pin_oe | peer_oe);
    initial
        forever #20 clk_i = ~clk_i;
    cfos_top i_dut
    (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .key_on_i(req[0]), .key_off_i(req[1]), .web_off_i(req[2]), .web_on_i(req[3]),
        .dig_pin_i(pin_lvl), .dig_pin_o(pin_o), .dig_pin_oe_o(pin_oe), .chan_out_o(chan)
    );
    cfos_peer #(.PULSE(cfos_pkg::PULSE_CYC)) i_peer
    (
        .clk_i(clk_i), .rst_i(rst_i), .fire_on_i(fire_on), .fire_off_i(fire_off),
        .wire_i(pin_lvl), .oe_o(peer_oe), .on_falls_o(on_falls), .off_falls_o(off_falls)
    );
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bail(input string what);
        err_total++;
        $display("[ERR] %s expected done seen timeout", what);
        tally_and_finish();
    endtask : bail
    task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 16);
        if (ack !== 1'b1)
            bail("bus ack");
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, 4'hf, d, q);
    endtask : wr
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(a, 1'b0, 4'hf, 32'h0000_0000, q);
        chk(what, exp, q);
    endtask : rd_chk
    task automatic wait_chan(input int i, input logic v, input int lim, output int n);
        n = 0;
        while (chan[i] !== v && n < lim)
        begin
            @(posedge clk_i);
            n++;
        end
        if (chan[i] !== v)
            bail("channel wait");
    endtask : wait_chan
    task automatic pulse_req(input int b);
        @(posedge clk_i);
        req[b] <= 1'b1;
        @(posedge clk_i);
        req[b] <= 1'b0;
    endtask : pulse_req
    task automatic bad_pin(input logic [31:0] d);
        logic [31:0] q;
        wr(cfos_pkg::ADR_PINFN, d);
        wb(cfos_pkg::ADR_PINFN, 1'b0, 4'hf, 32'h0000_0000, q);
        chk("pin function kept", 32'h0000_01fe, q & 32'h0000_01ff);
    endtask : bad_pin
    task automatic t_reset();
        logic [31:0] q;
        chk("chan_out", 32'h0000_0000, 32'(chan));
        chk("pin oe", 32'h0000_0000, 32'(pin_oe));
        chk("pin out", 32'h0000_0000, 32'(pin_o));
        rd_chk("ctrl", cfos_pkg::ADR_CTRL, 32'h0000_0000);
        rd_chk("pinfn", cfos_pkg::ADR_PINFN, 32'h0000_0000);
        rd_chk("offset", cfos_pkg::ADR_OFFSET, 32'h0000_0000);
        rd_chk("status", cfos_pkg::ADR_STATUS, 32'h0000_0000);
        wr(8'h44, 32'hffff_ffff);
        rd_chk("unmapped", 8'h44, 32'h0000_0000);
        wr(cfos_pkg::ADR_DON_BASE, 32'h0000_0005);
        rd_chk("on delay", cfos_pkg::ADR_DON_BASE, 32'h0000_0000);
        wb(cfos_pkg::ADR_CTRL, 1'b1, 4'h0, 32'h0000_00ff, q);
        rd_chk("ctrl no lanes", cfos_pkg::ADR_CTRL, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_pinfn();
        for (int k = 4; k < 8; k++)
        begin
            wr(cfos_pkg::ADR_PINFN, 32'(k + 8));
            rd_chk("on line", cfos_pkg::ADR_PINFN, 32'(k + 8));
        end
        wr(cfos_pkg::ADR_PINFN, 32'h0000_00fe);
        rd_chk("on and off lines", cfos_pkg::ADR_PINFN, 32'h0000_00fe);
        bad_pin(32'h0000_00fa);
        bad_pin(32'h0000_00be);
        bad_pin(32'h0000_00dd);
        wr(cfos_pkg::ADR_PINFN, 32'h0000_00fe);
        $display("test pin function done");
    endtask : t_pinfn
    task automatic t_fire();
        int ln;
        int n;
        logic [7:0] exp_on;
        logic [7:0] exp_off;
        exp_on = on_falls;
        exp_off = off_falls;
        wr(cfos_pkg::ADR_CTRL, 32'h0000_0001);
        for (int k = 0; k < 5; k++)
        begin
            ln = (k < 2) ? 6 : 7;
            if (k == 0)
                wr(cfos_pkg::ADR_CMD, 32'h0000_0001);
            else if (k == 4)
                wr(cfos_pkg::ADR_CMD, 32'h0000_0002);
            else
                pulse_req(k - 1);
            n = 0;
            while (pin_oe[ln] !== 1'b1 && n < 10)
            begin
                @(posedge clk_i);
                n++;
            end
            chk("line pulled low", 32'h0000_0001, 32'(pin_oe[ln]));
            n = 0;
            while (pin_oe[ln] === 1'b1 && n < 400)
            begin
                @(posedge clk_i);
                n++;
            end
            chk("pulse width", 32'(cfos_pkg::PULSE_CYC), 32'(n));
            repeat (8) @(posedge clk_i);
            if (ln == 6)
                exp_on++;
            else
                exp_off++;
            chk("peer on edges", 32'(exp_on), 32'(on_falls));
            chk("peer off edges", 32'(exp_off), 32'(off_falls));
        end
        chk("uncoupled idle", 32'h0000_0000, 32'(chan));
        $display("test request sources done");
    endtask : t_fire
    task automatic t_on();
        int n;
        logic [31:0] q;
        wr(cfos_pkg::ADR_CTRL, 32'h0000_0033);
        wr(cfos_pkg::ADR_OFFSET, 32'(OFS));
        for (int i = 0; i < 4; i++)
        begin
            wr(cfos_pkg::ADR_DON_BASE + 8'(4 * i), (i == 1) ? 32'h0000_0001 : 32'h0000_0000);
            wr(cfos_pkg::ADR_DOFF_BASE + 8'(4 * i), 32'h0000_0000);
        end
        pulse_req(3);
        wait_chan(0, 1'b1, 2 * TICK + 1000, n);
        chk("offset waited", 32'h0000_0001, 32'(n >= TICK - 1000));
        chk("first group", 32'h0000_000d, 32'(chan));
        wait_chan(1, 1'b1, TICK + 200, n);
        chk("own delay after offset", 32'h0000_0001, 32'(n >= TICK - 100));
        wb(cfos_pkg::ADR_STATUS, 1'b0, 4'hf, 32'h0000_0000, q);
        chk("status outputs", 32'h0000_000f, q & 32'h0000_00ff);
        $display("test coupled on done");
    endtask : t_on
    task automatic t_off();
        int n;
        wr(cfos_pkg::ADR_OFFSET, 32'h0000_0003);
        @(posedge clk_i);
        fire_off <= 1'b1;
        @(posedge clk_i);
        fire_off <= 1'b0;
        wait_chan(0, 1'b0, TICK + 200, n);
        repeat (4) @(posedge clk_i);
        chk("all off", 32'h0000_0000, 32'(chan));
        wr(cfos_pkg::ADR_OFFSET, 32'h0000_0000);
        wr(cfos_pkg::ADR_DON_BASE + 8'h04, 32'h0000_0000);
        @(posedge clk_i);
        fire_on <= 1'b1;
        @(posedge clk_i);
        fire_on <= 1'b0;
        wait_chan(0, 1'b1, 200, n);
        repeat (4) @(posedge clk_i);
        chk("peer on all", 32'h0000_000f, 32'(chan));
        repeat (300) @(posedge clk_i);
        chk("lines idle", 32'h0000_00ff, 32'(pin_lvl));
        $display("test peer off done");
    endtask : t_off
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_pinfn();
        t_fire();
        t_on();
        t_off();
        tally_and_finish();
    end
endmodule : cfos_top_tb
